// ===== design/bsq_top.sv
// buck sequencing, watchdog debounce and input mapping with wishbone registers
//
// Register access over Wishbone was chosen for this implementation.
`include "bsq_cfg.svh"

// Overview of operation
// - regulator 3 turns on startup code times step after enable rises
// - regulator 4 turns on startup code times step after enable rises
// - regulator 1 turns off shutdown code times step after enable falls
// - regulator 2 turns off shutdown code times step after enable falls
// - regulator 3 turns off shutdown code times step after enable falls
// - regulator 4 turns off shutdown code times step after enable falls
// - watchdog input debounced: 001 0.8, 010 1.6, 011 3.2 ms
// - debounce 100 6.4, 101 12.8, 111 51.2 ms, 000 none
// - input one role from upper nibble of function select
// - input zero role from lower nibble of function select
// - role 0 global enable, 1 to 4 regulator enables
// - role 5 global voltage select, 6 to 9 regulator voltage selects
// - role 10 global low power, 11 and 12 regulators 1 and 2
// - delay step 1 ms when step bit clear, 2 ms when set
// - startup delays count from enable pin or global enable rising
// - regulator enabled when software bit or mapped input is high
module bsq_top
   import bsq_pkg::*;
#(
   parameter int STEP_CYCLES = `BSQ_STEP_US * `BSQ_CLK_MHZ,
   parameter int DEB_CYCLES  = `BSQ_DEB_UNIT_US * `BSQ_CLK_MHZ,
   parameter int CNT_W       = 23
)(
   input  wire logic        clk_i,                          // 100 MHz clock
   input  wire logic        rst_i,                          // sync reset, high
   input  wire logic        wb_cyc_i,                       // bus cycle
   input  wire logic        wb_stb_i,                       // strobe
   input  wire logic        wb_we_i,                        // write enable
   input  wire logic [6:0]  wb_adr_i,                       // byte address
   input  wire logic [3:0]  wb_sel_i,                       // byte enables
   input  wire logic [31:0] wb_dat_i,                       // write data
   output logic             wb_ack_o,                       // acknowledge
   output logic [31:0]      wb_dat_o,                       // read data
   input  wire logic        enable_pin_i,                   // enable pin
   input  wire logic        general_input_zero_i,           // input zero
   input  wire logic        general_input_one_i,            // input one
   input  wire logic        watchdog_reset_input_n_i,       // watchdog reset, low
   output logic [3:0]       regulator_enable_o,             // regulator 1..4 on
   output logic [3:0]       regulator_voltage_select_o,     // regulator 1..4 vsel
   output logic [3:0]       regulator_low_power_request_o,  // regulator 1..4 lpm
   output logic             global_voltage_select_o,        // global vsel
   output logic             global_low_power_request_o,     // global lpm
   output logic             watchdog_reset_n_o              // debounced watchdog
);
   logic [7:0]             en_ctrl;
   logic                   delay_step_unit;
   logic [`BSQ_CODE_W-1:0] regulator3_startup_code;
   logic [`BSQ_CODE_W-1:0] regulator4_startup_code;
   logic [`BSQ_CODE_W-1:0] shdn_code [4];
   logic [`BSQ_DEB_W-1:0]  watchdog_debounce_code;
   logic [3:0]             input_zero_role_code;
   logic [3:0]             input_one_role_code;
   logic [`BSQ_CODE_W-1:0] stup_code [4];
   logic [4:0]             idx;
   logic                   wr;
   logic [31:0]            next_rdata;
   logic                   global_output_enable;
   logic                   enable_source;
   logic [3:0]             map_en;
   logic [3:0]             map_vsel;
   logic [3:0]             map_lpm;
   logic                   map_all_vsel;
   logic                   map_all_lpm;
   logic [3:0]             seq_on;
   logic [3:0]             sw_en;
   logic [3:0]             sw_lpm;
   logic [3:0]             gin;
   logic [7:0]             roles;

   assign idx = wb_adr_i[6:2];
   assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

   // one-cycle answer, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_ctrl                 <= `BSQ_RST_ZERO;
         delay_step_unit         <= 1'b0;
         regulator3_startup_code <= '0;
         regulator4_startup_code <= '0;
         shdn_code               <= '{default: '0};
         watchdog_debounce_code  <= `BSQ_DEB_W'(`BSQ_RST_WDOG_FILT);
         input_one_role_code     <= 4'(`BSQ_RST_FUNC >> 4);
         input_zero_role_code    <= 4'(`BSQ_RST_FUNC);
      end
      else if (wr)
      begin
         case (idx)
            `BSQ_IDX_EN_CTRL: en_ctrl                 <= wb_dat_i[7:0];
            `BSQ_IDX_STEP:    delay_step_unit         <= wb_dat_i[`BSQ_STEP_BIT];
            `BSQ_IDX_R3_STUP: regulator3_startup_code <= wb_dat_i[`BSQ_CODE_W-1:0];
            `BSQ_IDX_R4_STUP: regulator4_startup_code <= wb_dat_i[`BSQ_CODE_W-1:0];
            `BSQ_IDX_R1_SHDN: shdn_code[0]            <= wb_dat_i[`BSQ_CODE_W-1:0];
            `BSQ_IDX_R2_SHDN: shdn_code[1]            <= wb_dat_i[`BSQ_CODE_W-1:0];
            `BSQ_IDX_R3_SHDN: shdn_code[2]            <= wb_dat_i[`BSQ_CODE_W-1:0];
            `BSQ_IDX_R4_SHDN: shdn_code[3]            <= wb_dat_i[`BSQ_CODE_W-1:0];
            `BSQ_IDX_WDOG_FILT: watchdog_debounce_code <= wb_dat_i[`BSQ_DEB_W-1:0];
            `BSQ_IDX_FUNC:
            begin
               input_one_role_code  <= wb_dat_i[7:4];
               input_zero_role_code <= wb_dat_i[3:0];
            end
            default: ;
         endcase
      end
   end

   // reserved bits and unmapped words read as zero
   always_comb
   begin
      next_rdata = '0;
      case (idx)
         `BSQ_IDX_EN_CTRL: next_rdata[7:0] = en_ctrl;
         `BSQ_IDX_STEP:    next_rdata[`BSQ_STEP_BIT] = delay_step_unit;
         `BSQ_IDX_R3_STUP: next_rdata[`BSQ_CODE_W-1:0] = regulator3_startup_code;
         `BSQ_IDX_R4_STUP: next_rdata[`BSQ_CODE_W-1:0] = regulator4_startup_code;
         `BSQ_IDX_R1_SHDN: next_rdata[`BSQ_CODE_W-1:0] = shdn_code[0];
         `BSQ_IDX_R2_SHDN: next_rdata[`BSQ_CODE_W-1:0] = shdn_code[1];
         `BSQ_IDX_R3_SHDN: next_rdata[`BSQ_CODE_W-1:0] = shdn_code[2];
         `BSQ_IDX_R4_SHDN: next_rdata[`BSQ_CODE_W-1:0] = shdn_code[3];
         `BSQ_IDX_WDOG_FILT: next_rdata[`BSQ_DEB_W-1:0] = watchdog_debounce_code;
         `BSQ_IDX_FUNC:    next_rdata[7:0] = {input_one_role_code, input_zero_role_code};
         `BSQ_IDX_STATUS:  next_rdata[4:0] = {watchdog_reset_n_o, regulator_enable_o};
         default:          next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= '0;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
         wb_dat_o <= next_rdata;
   end

   // role decode of both general inputs; codes above 12 map to nothing
   assign gin   = {2'b00, general_input_one_i, general_input_zero_i};
   assign roles = {input_one_role_code, input_zero_role_code};

   always_comb
   begin
      global_output_enable = 1'b0;
      map_en               = '0;
      map_vsel             = '0;
      map_lpm              = '0;
      map_all_vsel         = 1'b0;
      map_all_lpm          = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         global_output_enable |= gin[i] && roles[4*i +: 4] == BSQ_FN_ALL_EN;
         map_all_vsel         |= gin[i] && roles[4*i +: 4] == BSQ_FN_ALL_VSEL;
         map_all_lpm          |= gin[i] && roles[4*i +: 4] == BSQ_FN_ALL_LPM;
         for (int k = 0; k < 4; k++)
         begin
            map_en[k]   |= gin[i] && roles[4*i +: 4] == 4'(BSQ_FN_R1_EN) + 4'(k);
            map_vsel[k] |= gin[i] && roles[4*i +: 4] == 4'(BSQ_FN_R1_VSEL) + 4'(k);
         end
         for (int k = 0; k < 2; k++)
            map_lpm[k] |= gin[i] && roles[4*i +: 4] == 4'(BSQ_FN_R1_LPM) + 4'(k);
      end
   end

   assign enable_source = enable_pin_i || global_output_enable;
   assign stup_code[0]  = '0;
   assign stup_code[1]  = '0;
   assign stup_code[2]  = regulator3_startup_code;
   assign stup_code[3]  = regulator4_startup_code;

   for (genvar k = 0; k < 4; k++)
   begin : g_seq
      assign sw_en[k]  = en_ctrl[2*k];
      assign sw_lpm[k] = en_ctrl[2*k+1];
      bsq_seq_timer #(
         .STEP_CYCLES (STEP_CYCLES),
         .CNT_W       (CNT_W)
      ) bsq_seq_timer_inst (
         .clk_i         (clk_i),
         .rst_i         (rst_i),
         .src_i         (enable_source),
         .up_code_i     (stup_code[k]),
         .dn_code_i     (shdn_code[k]),
         .step_double_i (delay_step_unit),
         .on_o          (seq_on[k])
      );
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         regulator_enable_o            <= '0;
         regulator_voltage_select_o    <= '0;
         regulator_low_power_request_o <= '0;
         global_voltage_select_o       <= 1'b0;
         global_low_power_request_o    <= 1'b0;
      end
      else
      begin
         regulator_enable_o            <= seq_on | sw_en | map_en;
         regulator_voltage_select_o    <= map_vsel;
         regulator_low_power_request_o <= map_lpm | sw_lpm;
         global_voltage_select_o       <= map_all_vsel;
         global_low_power_request_o    <= map_all_lpm;
      end
   end

   bsq_debounce #(
      .UNIT_CYCLES (DEB_CYCLES),
      .CNT_W       (CNT_W)
   ) bsq_debounce_inst (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .in_n_i  (watchdog_reset_input_n_i),
      .code_i  (watchdog_debounce_code),
      .out_n_o (watchdog_reset_n_o)
   );

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_sw_enable;
      @(posedge clk_i) disable iff (rst_i)
      en_ctrl[0] |=> regulator_enable_o[0];
   endproperty
   a_sw_enable: assert property (p_sw_enable) else $error("software enable ignored");

   property p_map_reg1_en;
      @(posedge clk_i) disable iff (rst_i)
      (general_input_zero_i && input_zero_role_code == 4'h1) |=> regulator_enable_o[0];
   endproperty
   a_map_reg1_en: assert property (p_map_reg1_en) else $error("input zero enable lost");

   property p_map_vsel;
      @(posedge clk_i) disable iff (rst_i)
      (general_input_one_i && input_one_role_code == 4'h9) |=> regulator_voltage_select_o[3];
   endproperty
   a_map_vsel: assert property (p_map_vsel) else $error("input one vsel lost");

   property p_map_global_low_power_request;
      @(posedge clk_i) disable iff (rst_i)
      global_low_power_request_o |-> $past(general_input_zero_i && input_zero_role_code == 4'ha)
                                  || $past(general_input_one_i && input_one_role_code == 4'ha);
   endproperty
   a_map_global_low_power_request: assert property (p_map_global_low_power_request) else $error("low power without source");

   property p_reserved_zero;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && idx == `BSQ_IDX_WDOG_FILT) |=> wb_dat_o[31:3] == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_role_write;
      @(posedge clk_i) disable iff (rst_i)
      (wr && idx == `BSQ_IDX_FUNC) |=> input_one_role_code == $past(wb_dat_i[7:4])
                                    && input_zero_role_code == $past(wb_dat_i[3:0]);
   endproperty
   a_role_write: assert property (p_role_write) else $error("function select not stored");

   property p_ack_answer;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

   property p_sel_ignored;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_sel_i[0]) |=> $stable(en_ctrl) && $stable(roles);
   endproperty
   a_sel_ignored: assert property (p_sel_ignored) else $error("write without low byte lane stored");

   property p_all_vsel;
      @(posedge clk_i) disable iff (rst_i)
      (general_input_zero_i && input_zero_role_code == 4'h5) |=> global_voltage_select_o;
   endproperty
   a_all_vsel: assert property (p_all_vsel) else $error("input zero global vsel lost");

   property p_map_lpm2;
      @(posedge clk_i) disable iff (rst_i)
      (general_input_one_i && input_one_role_code == 4'hc) |=> regulator_low_power_request_o[1];
   endproperty
   a_map_lpm2: assert property (p_map_lpm2) else $error("input one low power lost");

   property p_status_read;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && idx == `BSQ_IDX_STATUS)
         |=> wb_dat_o[4:0] == {$past(watchdog_reset_n_o), $past(regulator_enable_o)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_step_write;
      @(posedge clk_i) disable iff (rst_i)
      (wr && idx == `BSQ_IDX_STEP) |=> delay_step_unit == $past(wb_dat_i[`BSQ_STEP_BIT]);
   endproperty
   a_step_write: assert property (p_step_write) else $error("step select not stored");
endmodule // bsq_top

// ===== design/bsq_cfg.svh
// register map, field layout, reset values and timing figures of the sequencer
`ifndef BSQ_CFG_SVH
`define BSQ_CFG_SVH
`define BSQ_IDX_EN_CTRL   5'h06
`define BSQ_IDX_STEP      5'h07
`define BSQ_IDX_R3_STUP   5'h08
`define BSQ_IDX_R4_STUP   5'h09
`define BSQ_IDX_R1_SHDN   5'h0a
`define BSQ_IDX_R2_SHDN   5'h0b
`define BSQ_IDX_R3_SHDN   5'h0c
`define BSQ_IDX_R4_SHDN   5'h0d
`define BSQ_IDX_WDOG_FILT 5'h0e
`define BSQ_IDX_FUNC      5'h0f
`define BSQ_IDX_STATUS    5'h16
`define BSQ_CODE_W        5
`define BSQ_DEB_W         3
`define BSQ_STEP_BIT      7
`define BSQ_RST_ZERO      8'h00
`define BSQ_RST_WDOG_FILT 8'h02
`define BSQ_RST_FUNC      8'h43
`define BSQ_CLK_MHZ       100
`define BSQ_STEP_US       1000
`define BSQ_DEB_UNIT_US   800
`define BSQ_DEB_MAX_SHIFT 6
`endif

// ===== design/bsq_pkg.sv
// types shared by the sequencer modules
package bsq_pkg;
   typedef enum logic [3:0] {
      BSQ_SEQ_OFF  = 4'b0001,
      BSQ_SEQ_UP   = 4'b0010,
      BSQ_SEQ_ON   = 4'b0100,
      BSQ_SEQ_DOWN = 4'b1000
   } bsq_seq_type;

   typedef enum logic [3:0] {
      BSQ_FN_ALL_EN   = 4'h0,
      BSQ_FN_R1_EN    = 4'h1,
      BSQ_FN_ALL_VSEL = 4'h5,
      BSQ_FN_R1_VSEL  = 4'h6,
      BSQ_FN_ALL_LPM  = 4'ha,
      BSQ_FN_R1_LPM   = 4'hb
   } bsq_role_type;
endpackage

// ===== design/bsq_seq_timer.sv
// one regulator's startup and shutdown delay sequencer
`include "bsq_cfg.svh"
module bsq_seq_timer
   import bsq_pkg::*;
#(
   parameter int STEP_CYCLES = 100000,
   parameter int CNT_W       = 23
)(
   input  wire logic                   clk_i,         // system clock
   input  wire logic                   rst_i,         // sync reset
   input  wire logic                   src_i,         // enable source level
   input  wire logic [`BSQ_CODE_W-1:0] up_code_i,     // startup code
   input  wire logic [`BSQ_CODE_W-1:0] dn_code_i,     // shutdown code
   input  wire logic                   step_double_i, // 2 ms step
   output logic                        on_o           // sequenced enable
);
   bsq_seq_type      state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] step_len;
   logic [CNT_W-1:0] up_len;
   logic [CNT_W-1:0] dn_len;

   if (STEP_CYCLES < 1 || 64'(62) * 64'(STEP_CYCLES) >= (64'(1) << CNT_W))
   begin : g_chk
      $error("bsq_seq_timer: counter too narrow for step");
   end

   assign step_len = step_double_i ? CNT_W'(2 * STEP_CYCLES) : CNT_W'(STEP_CYCLES);
   assign up_len   = CNT_W'(up_code_i * step_len) - CNT_W'(1);
   assign dn_len   = CNT_W'(dn_code_i * step_len) - CNT_W'(1);

   // level-following sequencer, each instance independent
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= BSQ_SEQ_OFF;
         cnt   <= '0;
      end
      else
      begin
         case (state)
            BSQ_SEQ_OFF:
               if (src_i)
               begin
                  state <= (up_code_i == '0) ? BSQ_SEQ_ON : BSQ_SEQ_UP;
                  cnt   <= up_len;
               end
            BSQ_SEQ_UP:
               if (!src_i)
                  state <= BSQ_SEQ_OFF;
               else if (cnt == '0)
                  state <= BSQ_SEQ_ON;
               else
                  cnt <= cnt - CNT_W'(1);
            BSQ_SEQ_ON:
               if (!src_i)
               begin
                  state <= (dn_code_i == '0) ? BSQ_SEQ_OFF : BSQ_SEQ_DOWN;
                  cnt   <= dn_len;
               end
            BSQ_SEQ_DOWN:
               if (src_i)
                  state <= BSQ_SEQ_ON;
               else if (cnt == '0)
                  state <= BSQ_SEQ_OFF;
               else
                  cnt <= cnt - CNT_W'(1);
            default:
               state <= BSQ_SEQ_OFF;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         on_o <= 1'b0;
      else
         on_o <= (state == BSQ_SEQ_ON) || (state == BSQ_SEQ_DOWN);
   end

   property p_up_load;
      @(posedge clk_i) disable iff (rst_i)
      (state == BSQ_SEQ_OFF && src_i && up_code_i != '0)
         |=> state == BSQ_SEQ_UP && cnt == CNT_W'($past(up_code_i) * $past(step_len)) - CNT_W'(1);
   endproperty
   a_up_load: assert property (p_up_load) else $error("startup count wrong");

   property p_dn_zero;
      @(posedge clk_i) disable iff (rst_i)
      (state == BSQ_SEQ_ON && !src_i && dn_code_i == '0) |=> ##1 !on_o;
   endproperty
   a_dn_zero: assert property (p_dn_zero) else $error("zero shutdown not immediate");

   property p_dn_abort;
      @(posedge clk_i) disable iff (rst_i)
      (state == BSQ_SEQ_DOWN && src_i) |=> state == BSQ_SEQ_ON ##1 on_o;
   endproperty
   a_dn_abort: assert property (p_dn_abort) else $error("shutdown not cancelled");
endmodule // bsq_seq_timer

// ===== design/bsq_debounce.sv
// debounce filter for the active-low watchdog reset input
`include "bsq_cfg.svh"
module bsq_debounce
#(
   parameter int UNIT_CYCLES = 80000,
   parameter int CNT_W       = 23
)(
   input  wire logic                  clk_i,   // system clock
   input  wire logic                  rst_i,   // sync reset
   input  wire logic                  in_n_i,  // raw input, active low
   input  wire logic [`BSQ_DEB_W-1:0] code_i,  // debounce code
   output logic                       out_n_o  // filtered, active low
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] len;

   if (UNIT_CYCLES < 1 || (64'(UNIT_CYCLES) << `BSQ_DEB_MAX_SHIFT) >= (64'(1) << CNT_W))
   begin : g_chk
      $error("bsq_debounce: counter too narrow");
   end

   // 0.8 ms doubled per code step; reserved 110 falls back to the longest
   always_comb
   begin
      if (code_i == 3'h0)
         len = '0;
      else if (code_i >= 3'h6)
         len = CNT_W'(UNIT_CYCLES) << `BSQ_DEB_MAX_SHIFT;
      else
         len = CNT_W'(UNIT_CYCLES) << (code_i - 3'h1);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_n_o <= 1'b1;
         cnt     <= '0;
      end
      else if (in_n_i == out_n_o)
         cnt <= '0;
      else if (cnt + CNT_W'(1) >= len)
      begin
         out_n_o <= in_n_i;
         cnt     <= '0;
      end
      else
         cnt <= cnt + CNT_W'(1);
   end

   property p_change_cause;
      @(posedge clk_i) disable iff (rst_i)
      $changed(out_n_o) |-> $past(in_n_i) != $past(out_n_o);
   endproperty
   a_change_cause: assert property (p_change_cause) else $error("output moved without input");

   property p_no_filter;
      @(posedge clk_i) disable iff (rst_i)
      (code_i == 3'h0 && in_n_i != out_n_o) |=> out_n_o == $past(in_n_i);
   endproperty
   a_no_filter: assert property (p_no_filter) else $error("code 000 must pass through");

   property p_hold_short;
      @(posedge clk_i) disable iff (rst_i)
      (UNIT_CYCLES > 1 && code_i == 3'h1 && in_n_i != out_n_o && cnt == '0) ##1 (in_n_i != out_n_o)
         |-> $stable(out_n_o);
   endproperty
   a_hold_short: assert property (p_hold_short) else $error("debounce ended too soon");
endmodule // bsq_debounce

// ===== test/bsq_host_model.sv
// host processor model driving the enable, input and watchdog pins
module bsq_host_model (
   input  wire logic clk_i,     // system clock
   output logic      enable_o,  // enable pin
   output logic      in_zero_o, // input zero
   output logic      in_one_o,  // input one
   output logic      wdt_n_o    // watchdog, low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      enable_o = 1'b0;
      in_zero_o = 1'b0;
      in_one_o = 1'b0;
      wdt_n_o = 1'b1;
   end
   // pins change only just after a rising edge
   task automatic drive(input int which, input logic v);
      @(posedge clk_i);
      case (which)
         0: enable_o <= v;
         1: in_zero_o <= v;
         2: in_one_o <= v;
         default: wdt_n_o <= v;
      endcase
   endtask
endmodule // bsq_host_model

// ===== test/bsq_top_bench.sv
// self-checking bench for the sequencer top
module bsq_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_sel_i = 4'h1;
   logic [6:0]  wb_adr_i = 7'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic        wb_ack_o;
   logic [31:0] wb_dat_o;
   logic [3:0]  en_o, vsel_o, lpm_o;
   logic        pin, in0, in1, wdt_n, gvsel, glpm, wdt_out_n;
   logic [7:0]  rd;
   int          mismatches = 0;
   int          checks = 0;
   int          cycles = 0;
   int          hit[4];

   bsq_top #(.STEP_CYCLES(4), .DEB_CYCLES(2), .CNT_W(23)) bsq_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .enable_pin_i(pin),
      .general_input_zero_i(in0), .general_input_one_i(in1),
      .watchdog_reset_input_n_i(wdt_n), .regulator_enable_o(en_o),
      .regulator_voltage_select_o(vsel_o), .regulator_low_power_request_o(lpm_o),
      .global_voltage_select_o(gvsel), .global_low_power_request_o(glpm),
      .watchdog_reset_n_o(wdt_out_n));

   bsq_host_model bsq_host_model_inst (.clk_i(clk_i), .enable_o(pin),
      .in_zero_o(in0), .in_one_o(in1), .wdt_n_o(wdt_n));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus(input logic we, input logic [4:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      if (!we)
         check("upper", {8'h0, wb_dat_o[31:8]}, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wrchk(input logic [4:0] idx, input logic [7:0] d, input logic [7:0] exp);
      bus(1'b1, idx, d);
      bus(1'b0, idx, 8'h00);
      check("reg", rd, exp);
   endtask

   // first cycle at which each enable reaches lvl
   task automatic seq(input int which, input logic lvl, input int e[4]);
      hit = '{0, 0, 0, 0};
      bsq_host_model_inst.drive(which, lvl);
      for (int n = 1; n <= 100; n++)
      begin
         @(negedge clk_i);
         for (int k = 0; k < 4; k++)
            if (hit[k] == 0 && en_o[k] === lvl)
               hit[k] = n;
      end
      for (int k = 0; k < 4; k++)
         check("edge", hit[k], e[k]);
   endtask

   function automatic logic [13:0] role_vec(input int c);
      case (c) inside
         [1:4]: return 14'h0001 << (c - 1);
         [6:9]: return 14'h0010 << (c - 6);
         [11:12]: return 14'h0100 << (c - 11);
         5: return 14'h1000;
         10: return 14'h2000;
         default: return 14'h0000;
      endcase
   endfunction

   task automatic regs_scn;
      logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h43};
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b0, 5'h08 + i[4:0], 8'h00);
         check("reset", rd, rv[i]);
      end
      for (int i = 8; i < 14; i++)
         wrchk(i[4:0], 8'hff, 8'h1f);
      wrchk(5'h0e, 8'hff, 8'h07);
      wrchk(5'h0f, 8'hdd, 8'hdd);
      wrchk(5'h1f, 8'hff, 8'h00);
   endtask

   task automatic seq_scn;
      logic [7:0] cfg[6] = '{8'h02, 8'h05, 8'h01, 8'h00, 8'h03, 8'h02};
      for (int i = 0; i < 6; i++)
         bus(1'b1, 5'h08 + i[4:0], cfg[i]);
      seq(0, 1'b1, '{4, 4, 12, 24});
      seq(0, 1'b0, '{8, 4, 16, 12});
      bus(1'b1, 5'h07, 8'h80);
      bus(1'b1, 5'h0f, 8'hd0);
      seq(1, 1'b1, '{4, 4, 20, 44});
      seq(1, 1'b0, '{12, 4, 28, 20});
      // source back during the shutdown wait keeps regulators 1, 3 and 4 on; regulator 2 drops at once and comes back
      bsq_host_model_inst.drive(1, 1'b1);
      repeat (50) @(negedge clk_i);
      bsq_host_model_inst.drive(1, 1'b0);
      repeat (5) @(negedge clk_i);
      bsq_host_model_inst.drive(1, 1'b1);
      repeat (40) @(negedge clk_i);
      check("cancel", en_o, 4'hf);
      bsq_host_model_inst.drive(1, 1'b0);
      repeat (40) @(negedge clk_i);
   endtask

   task automatic map_scn;
      for (int i = 0; i < 2; i++)
         for (int c = 1; c < 14; c++)
         begin
            bus(1'b1, 5'h0f, (i == 1) ? {c[3:0], 4'hd} : {4'hd, c[3:0]});
            bsq_host_model_inst.drive(i + 1, 1'b1);
            repeat (3) @(negedge clk_i);
            check("roles", {glpm, gvsel, lpm_o, vsel_o, en_o}, role_vec(c));
            bsq_host_model_inst.drive(i + 1, 1'b0);
            repeat (3) @(negedge clk_i);
         end
   endtask

   task automatic sw_scn;
      bus(1'b1, 5'h06, 8'hc0);
      repeat (3) @(negedge clk_i);
      check("soft", {lpm_o, en_o}, 8'h88);
      bus(1'b0, 5'h16, 8'h00);
      check("status", rd, 8'h18);
      wb_sel_i <= 4'he;
      bus(1'b1, 5'h06, 8'h00);
      wb_sel_i <= 4'h1;
      bus(1'b0, 5'h06, 8'h00);
      check("sel", rd, 8'hc0);
      bus(1'b1, 5'h06, 8'h00);
   endtask

   task automatic wdt_scn;
      int d;
      int n;
      int codes[5] = '{0, 1, 3, 5, 7};
      foreach (codes[j])
      begin
         bus(1'b1, 5'h0e, codes[j][7:0]);
         d = (codes[j] == 0) ? 0 : (codes[j] == 7) ? 128 : 2 << (codes[j] - 1);
         for (int v = 0; v < 2; v++)
         begin
            bsq_host_model_inst.drive(3, v[0]);
            n = 0;
            do
            begin
               @(negedge clk_i);
               n++;
            end
            while (wdt_out_n !== v[0] && n < 300);
            check("debounce", n, (d == 0) ? 2 : d + 1);
         end
      end
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      regs_scn();
      seq_scn();
      map_scn();
      sw_scn();
      wdt_scn();
      give_verdict();
   end
endmodule // bsq_top_bench
